// [logic/lcdp_pkg.sv]
// Shared constants, field layouts and types of the display host port.
package lcdp_pkg;

	// -----------------------------------------------------------------
	// Clock and timing
	// -----------------------------------------------------------------
	localparam int CLK_MHZ = 40;
	localparam int OSC_SETTLE_US = 10000;
	localparam int OSC_SETTLE_CYC = OSC_SETTLE_US * CLK_MHZ;

	// -----------------------------------------------------------------
	// Sizes
	// -----------------------------------------------------------------
	localparam int ADDR_W = 11;
	localparam int RAM_WORDS = 2048;
	localparam int DOTS = 128;
	localparam int ROW_WORDS = 16;
	localparam int FIFO_DEPTH = 16;
	localparam int SERIAL_LAST = 16;

	// -----------------------------------------------------------------
	// Interface mode strap codes
	// -----------------------------------------------------------------
	localparam logic [2:0] MODE_68_16 = 3'h0;
	localparam logic [2:0] MODE_68_8 = 3'h1;
	localparam logic [2:0] MODE_80_16 = 3'h2;
	localparam logic [2:0] MODE_80_8 = 3'h3;
	localparam logic [2:0] MODE_SERIAL = 3'h4;

	// -----------------------------------------------------------------
	// Target pointer values
	// -----------------------------------------------------------------
	localparam logic [15:0] IDX_OSC = 16'h0000;
	localparam logic [15:0] IDX_DRIVER = 16'h0001;
	localparam logic [15:0] IDX_POWER = 16'h0003;
	localparam logic [15:0] IDX_CONTRAST = 16'h0004;
	localparam logic [15:0] IDX_ENTRY = 16'h0005;
	localparam logic [15:0] IDX_ROTATE = 16'h0006;
	localparam logic [15:0] IDX_DISPLAY = 16'h0007;
	localparam logic [15:0] IDX_MASK = 16'h0008;
	localparam logic [15:0] IDX_ADDR = 16'h0011;
	localparam logic [15:0] IDX_RAM = 16'h0012;

	// -----------------------------------------------------------------
	// Field positions
	// -----------------------------------------------------------------
	localparam int DRV_CMS_BIT = 9;
	localparam int DRV_SGS_BIT = 8;
	localparam int PWR_BS_LSB = 11;
	localparam int PWR_BT_LSB = 9;
	localparam int PWR_SLP_BIT = 1;
	localparam int PWR_STB_BIT = 0;
	localparam int ENT_DIR_BIT = 4;
	localparam int ENT_RDM_BIT = 3;
	localparam int ENT_OP_LSB = 0;
	localparam int DISP_ON_BIT = 0;
	localparam int OSC_START_BIT = 0;

	// -----------------------------------------------------------------
	// Values after reset
	// -----------------------------------------------------------------
	localparam logic [15:0] RST_DRIVER = 16'h000f;
	localparam logic [15:0] RST_POWER = 16'h0000;
	localparam logic [15:0] RST_CONTRAST = 16'h0000;
	localparam logic [15:0] RST_ENTRY = 16'h0010;
	localparam logic [15:0] RST_ROTATE = 16'h0000;
	localparam logic [15:0] RST_DISPLAY = 16'h0000;
	localparam logic [15:0] RST_MASK = 16'h0000;

	// -----------------------------------------------------------------
	// Logic operation codes
	// -----------------------------------------------------------------
	localparam logic [1:0] OP_REPLACE = 2'h0;
	localparam logic [1:0] OP_OR = 2'h1;
	localparam logic [1:0] OP_AND = 2'h2;
	localparam logic [1:0] OP_XOR = 2'h3;

	// -----------------------------------------------------------------
	// Types
	// -----------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic rs;
		logic [15:0] data;
	} lcdp_access_type;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [15:0] data;
	} lcdp_ram_write_type;

	typedef enum logic [1:0] {
		RF_HALT = 2'b00,
		RF_FETCH = 2'b01,
		RF_LATCH = 2'b10
	} lcdp_refresh_state_type;

endpackage : lcdp_pkg

// [logic/lcdp_host_port.sv]
// Host port, graphics memory, write staging FIFO and row refresh of the display controller.
// Operation
// - Straps choose 80-style 16/8-bit, 68-style 16/8-bit or clocked serial host bus.
// - Three 16-bit host registers: target pointer, write staging, read staging.
// - Select low write loads pointer; select low read ignored; select high writes/reads data.
// - Pixel writes land in write staging, then move to memory automatically.
// - First memory read after setup returns stale data; host discards it.
// - Logic operations take the stored operand from the read staging register.
// - All instructions except oscillator restart finish without wait states.
// - Address-set instruction loads the pixel address counter.
// - Each memory write steps the address counter by one, up or down.
// - Read-update mode bit decides whether a memory read advances the counter.
// - Memory holds 128x128 pixels at two bits each, 4096 bytes.
// - Write path offers rotation, per-bit write mask and logic operations.
// - Refresh reads and host memory writes use separate time slots.
// - Four gray levels come from frame rate control over three frames.
// - Commons within the programmed line count are selected; with common direction set, rows map from common 127 downward.
// - Segment row is latched once all 128 pixels of a row are gathered.
// - Common direction bit set reverses common order; segment direction bit clear reverses segment order.
// - Display off, standby or sleep drives all commons and segments to ground.
// - Oscillator halts in standby.
// - A row is sixteen words from 000; first segment pairs descend from D15.
// - Booster factor of two, five, six or seven; bias 1/4 to 1/11.
// - Contrast setting has 64 steps.
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------------
// Staging FIFO
// -----------------------------------------------------------------------
module lcdp_fifo #(
	parameter int WIDTH = 27,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] slot_q [DEPTH];
	logic [PW-1:0] wptr_q;
	logic [PW-1:0] rptr_q;
	logic [PW:0] count_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	generate
		if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
			$error("lcdp_fifo depth must be a power of two of at least 2");
		end
	endgenerate

	assign in_ready = (count_q != (PW+1)'(DEPTH));
	assign out_valid = (count_q != '0);
	assign out_data = slot_q[rptr_q];

	always_ff @(posedge clk_sys) begin
		if (clk_en && push) begin
			slot_q[wptr_q] <= in_data;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wptr_q <= '0;
			rptr_q <= '0;
			count_q <= '0;
		end else if (clk_en) begin
			wptr_q <= push ? wptr_q + 1'b1 : wptr_q;
			rptr_q <= pop ? rptr_q + 1'b1 : rptr_q;
			count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule : lcdp_fifo

// -----------------------------------------------------------------------
// Top: host port and display path
// -----------------------------------------------------------------------
module lcdp_host_port #(
	parameter int FIFO_DEPTH = lcdp_pkg::FIFO_DEPTH,
	parameter int OSC_SETTLE_CYCLES = lcdp_pkg::OSC_SETTLE_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	// Host bus
	input wire logic [2:0] interface_mode_straps,
	input wire logic cs_n,
	input wire logic register_select,
	input wire logic strobe_e_wr_scl,
	input wire logic dir_rw_rd_sda,
	input wire logic [15:0] db_in,
	output logic [15:0] db_out,
	output logic db_oe,
	// Display drivers
	output logic [127:0] com_out,
	output logic [127:0] seg_out,
	// Analog controls
	output logic [1:0] booster_factor,
	output logic [2:0] bias_select,
	output logic [5:0] contrast_level,
	output logic osc_running
);
	localparam int AW = lcdp_pkg::ADDR_W;
	localparam int SW = $clog2(OSC_SETTLE_CYCLES + 1);

	generate
		if (OSC_SETTLE_CYCLES < 1) begin : g_bad_settle
			$error("oscillator settle count must be at least one cycle");
		end
	endgenerate

	// -------------------------------------------------------------------
	// Strap capture and strobe edges
	// -------------------------------------------------------------------
	logic [2:0] mode_q;
	logic strb_prev_q;
	logic armed_q;
	logic dir_prev_q;
	logic half_q;
	logic [7:0] byte_hi_q;
	logic [15:0] ser_sh_q;
	logic [4:0] ser_cnt_q;

	wire is_ser = mode_q[2];
	wire is_80 = !mode_q[2] && mode_q[1];
	wire is_68 = !mode_q[2] && !mode_q[1];
	wire is_8b = !mode_q[2] && mode_q[0];
	// Strobe edges count only once the history flops hold a real pin sample.
	wire sel = !cs_n && armed_q;
	wire strb_rise = strobe_e_wr_scl && !strb_prev_q;
	wire strb_fall = !strobe_e_wr_scl && strb_prev_q;
	wire rd_fall = !dir_rw_rd_sda && dir_prev_q;
	wire wr_edge = sel && ((is_80 && strb_rise) || (is_68 && strb_fall && !dir_rw_rd_sda));
	wire rd_edge = sel && ((is_80 && rd_fall) || (is_68 && strb_rise && dir_rw_rd_sda));
	wire ser_rise = sel && is_ser && strb_rise;
	wire ser_done = ser_rise && (ser_cnt_q == 5'(lcdp_pkg::SERIAL_LAST));
	wire [15:0] par_word = is_8b ? {byte_hi_q, db_in[15:8]} : db_in;
	wire word_done = !is_8b || half_q;

	lcdp_pkg::lcdp_access_type acc;
	assign acc.wr = (wr_edge && word_done) || ser_done;
	assign acc.rd = rd_edge && word_done;
	assign acc.rs = is_ser ? ser_sh_q[15] : register_select;
	assign acc.data = is_ser ? {ser_sh_q[14:0], dir_rw_rd_sda} : par_word;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= lcdp_pkg::MODE_68_16;
			strb_prev_q <= 1'b0;
			armed_q <= 1'b0;
			dir_prev_q <= 1'b0;
		end else if (clk_en) begin
			mode_q <= interface_mode_straps;
			armed_q <= 1'b1;
			strb_prev_q <= strobe_e_wr_scl;
			dir_prev_q <= dir_rw_rd_sda;
		end
	end

	// Byte pairing, upper byte first, and serial shifting.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			half_q <= 1'b0;
			byte_hi_q <= 8'h00;
			ser_sh_q <= 16'h0000;
			ser_cnt_q <= 5'h00;
		end else if (clk_en) begin
			half_q <= (is_8b && (wr_edge || rd_edge)) ? !half_q : half_q;
			byte_hi_q <= (wr_edge && !half_q) ? db_in[15:8] : byte_hi_q;
			ser_sh_q <= ser_rise ? {ser_sh_q[14:0], dir_rw_rd_sda} : ser_sh_q;
			ser_cnt_q <= (!sel || ser_done) ? 5'h00 : (ser_rise ? ser_cnt_q + 5'h01 : ser_cnt_q);
		end
	end

	// -------------------------------------------------------------------
	// Host registers and control registers
	// -------------------------------------------------------------------
	logic [15:0] ptr_q;
	logic [15:0] wstage_q;
	logic [15:0] rstage_q;
	logic [15:0] driver_q;
	logic [15:0] power_q;
	logic [15:0] contrast_q;
	logic [15:0] entry_q;
	logic [15:0] rotate_q;
	logic [15:0] display_q;
	logic [15:0] mask_q;
	logic [AW-1:0] ac_q;
	logic stage_pend_q;
	logic [AW-1:0] stage_addr_q;
	logic osc_run_q;
	logic [SW-1:0] settle_q;
	logic [15:0] mem_q [lcdp_pkg::RAM_WORDS];

	wire data_wr = acc.wr && acc.rs;
	wire data_rd = acc.rd && acc.rs;
	wire wr_to = (data_wr && ptr_q == lcdp_pkg::IDX_OSC) && 1'b1;
	wire ram_wr = data_wr && (ptr_q == lcdp_pkg::IDX_RAM);
	wire addr_wr = data_wr && (ptr_q == lcdp_pkg::IDX_ADDR);
	wire stb = power_q[lcdp_pkg::PWR_STB_BIT];
	wire slp = power_q[lcdp_pkg::PWR_SLP_BIT];
	wire step_up = entry_q[lcdp_pkg::ENT_DIR_BIT];
	wire read_update_mode = entry_q[lcdp_pkg::ENT_RDM_BIT];
	wire [AW-1:0] ac_step = step_up ? ac_q + 1'b1 : ac_q - 1'b1;
	wire [15:0] mem_host = mem_q[ac_q];

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ptr_q <= 16'h0000;
			wstage_q <= 16'h0000;
			rstage_q <= 16'h0000;
		end else if (clk_en) begin
			ptr_q <= (acc.wr && !acc.rs) ? acc.data : ptr_q;
			wstage_q <= data_wr ? acc.data : wstage_q;
			rstage_q <= data_rd ? mem_host : rstage_q;
		end
	end

	// Control registers take effect on the cycle after the write.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			driver_q <= lcdp_pkg::RST_DRIVER;
			power_q <= lcdp_pkg::RST_POWER;
			contrast_q <= lcdp_pkg::RST_CONTRAST;
			entry_q <= lcdp_pkg::RST_ENTRY;
			rotate_q <= lcdp_pkg::RST_ROTATE;
			display_q <= lcdp_pkg::RST_DISPLAY;
			mask_q <= lcdp_pkg::RST_MASK;
		end else if (clk_en && data_wr) begin
			driver_q <= (ptr_q == lcdp_pkg::IDX_DRIVER) ? acc.data : driver_q;
			power_q <= (ptr_q == lcdp_pkg::IDX_POWER) ? acc.data : power_q;
			contrast_q <= (ptr_q == lcdp_pkg::IDX_CONTRAST) ? acc.data : contrast_q;
			entry_q <= (ptr_q == lcdp_pkg::IDX_ENTRY) ? acc.data : entry_q;
			rotate_q <= (ptr_q == lcdp_pkg::IDX_ROTATE) ? acc.data : rotate_q;
			display_q <= (ptr_q == lcdp_pkg::IDX_DISPLAY) ? acc.data : display_q;
			mask_q <= (ptr_q == lcdp_pkg::IDX_MASK) ? acc.data : mask_q;
		end
	end

	// Address counter: address set, write step, read step per read-update mode.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ac_q <= '0;
		end else if (clk_en) begin
			if (addr_wr) begin
				ac_q <= acc.data[AW-1:0];
			end else if (ram_wr || (data_rd && read_update_mode)) begin
				ac_q <= ac_step;
			end
		end
	end

	// Oscillator: standby halts it, a restart waits out the settle time.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			osc_run_q <= 1'b1;
			settle_q <= '0;
		end else if (clk_en) begin
			if (stb) begin
				osc_run_q <= 1'b0;
			end else if (wr_to && acc.data[lcdp_pkg::OSC_START_BIT]) begin
				osc_run_q <= 1'b1;
				settle_q <= SW'(OSC_SETTLE_CYCLES);
			end else if (settle_q != '0) begin
				settle_q <= settle_q - 1'b1;
			end
		end
	end

	// -------------------------------------------------------------------
	// Write path: rotate, logic operation, mask, FIFO, memory
	// -------------------------------------------------------------------
	wire [31:0] rot_dbl = {wstage_q, wstage_q} << rotate_q[3:0];
	wire [15:0] rot_data = rot_dbl[31:16];
	wire [1:0] op = entry_q[lcdp_pkg::ENT_OP_LSB +: 2];
	wire [15:0] op_data = (op == lcdp_pkg::OP_OR) ? (rot_data | rstage_q) :
		(op == lcdp_pkg::OP_AND) ? (rot_data & rstage_q) :
		(op == lcdp_pkg::OP_XOR) ? (rot_data ^ rstage_q) : rot_data;
	wire [15:0] merged = (op_data & ~mask_q) | (rstage_q & mask_q);

	lcdp_pkg::lcdp_ram_write_type push_item;
	lcdp_pkg::lcdp_ram_write_type drain_item;
	logic push_ready;
	logic drain_valid;
	logic phase_q;
	assign push_item.addr = stage_addr_q;
	assign push_item.data = merged;
	wire drain_fire = drain_valid && phase_q;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stage_pend_q <= 1'b0;
			stage_addr_q <= '0;
			phase_q <= 1'b0;
		end else if (clk_en) begin
			stage_pend_q <= ram_wr || (stage_pend_q && !push_ready);
			stage_addr_q <= ram_wr ? ac_q : stage_addr_q;
			phase_q <= !phase_q;
		end
	end

	lcdp_fifo #(
		.WIDTH($bits(lcdp_pkg::lcdp_ram_write_type)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.in_valid(stage_pend_q),
		.in_ready(push_ready),
		.in_data(push_item),
		.out_valid(drain_valid),
		.out_ready(phase_q),
		.out_data(drain_item)
	);

	// -------------------------------------------------------------------
	// Display refresh
	// -------------------------------------------------------------------
	lcdp_pkg::lcdp_refresh_state_type rf_q;
	logic [6:0] row_q;
	logic [3:0] word_q;
	logic [1:0] frame_q;
	logic [255:0] row_buf_q;
	logic [127:0] seg_row;
	logic [127:0] com_row;
	wire [6:0] last_row = {driver_q[3:0], 3'b111};
	wire sgs = driver_q[lcdp_pkg::DRV_SGS_BIT];
	wire common_direction = driver_q[lcdp_pkg::DRV_CMS_BIT];
	wire blank = !display_q[lcdp_pkg::DISP_ON_BIT] || stb || slp;
	wire clk_ok = osc_run_q && (settle_q == '0);
	wire [15:0] mem_disp = mem_q[{row_q, word_q}];

	genvar g;
	generate
		for (g = 0; g < lcdp_pkg::RAM_WORDS; g++) begin : g_mem
			always_ff @(posedge clk_sys) begin
				if (clk_en && drain_fire && drain_item.addr == AW'(g)) begin
					mem_q[g] <= drain_item.data;
				end
			end
		end
		for (g = 0; g < lcdp_pkg::DOTS; g++) begin : g_dot
			wire [1:0] pix = row_buf_q[255-2*g -: 2];
			wire lit = (pix == 2'h3) || (pix == 2'h2 && frame_q != 2'h2) ||
				(pix == 2'h1 && frame_q == 2'h0);
			assign seg_row[sgs ? g : 127-g] = lit;
			assign com_row[g] = (common_direction ? 7'(127-g) : 7'(g)) == row_q;
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rf_q <= lcdp_pkg::RF_HALT;
			row_q <= 7'h00;
			word_q <= 4'h0;
			frame_q <= 2'h0;
			row_buf_q <= '0;
		end else if (clk_en) begin
			case (rf_q)
				lcdp_pkg::RF_HALT: begin
					row_q <= 7'h00;
					word_q <= 4'h0;
					rf_q <= clk_ok ? lcdp_pkg::RF_FETCH : lcdp_pkg::RF_HALT;
				end
				lcdp_pkg::RF_FETCH: begin
					if (!clk_ok) begin
						rf_q <= lcdp_pkg::RF_HALT;
					end else if (!phase_q) begin
						row_buf_q <= {row_buf_q[239:0], mem_disp};
						word_q <= word_q + 4'h1;
						rf_q <= (word_q == 4'hf) ? lcdp_pkg::RF_LATCH : lcdp_pkg::RF_FETCH;
					end
				end
				lcdp_pkg::RF_LATCH: begin
					row_q <= (row_q >= last_row) ? 7'h00 : row_q + 7'h01;
					frame_q <= (row_q < last_row) ? frame_q :
						((frame_q == 2'h2) ? 2'h0 : frame_q + 2'h1);
					rf_q <= lcdp_pkg::RF_FETCH;
				end
				default: begin
					rf_q <= lcdp_pkg::RF_HALT;
				end
			endcase
		end
	end

	// -------------------------------------------------------------------
	// Outputs
	// -------------------------------------------------------------------
	wire [15:0] rd_word = is_8b ? {(half_q ? rstage_q[7:0] : rstage_q[15:8]), 8'h00} : rstage_q;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			db_out <= 16'h0000;
			db_oe <= 1'b0;
			com_out <= '0;
			seg_out <= '0;
			booster_factor <= 2'h0;
			bias_select <= 3'h0;
			contrast_level <= 6'h00;
			osc_running <= 1'b0;
		end else if (clk_en) begin
			if (rd_edge) begin
				db_out <= register_select ? rd_word : 16'h0000;
			end
			db_oe <= sel && !is_ser && (is_80 ? !dir_rw_rd_sda : (strobe_e_wr_scl && dir_rw_rd_sda));
			if (blank) begin
				com_out <= '0;
				seg_out <= '0;
			end else if (rf_q == lcdp_pkg::RF_LATCH) begin
				com_out <= com_row;
				seg_out <= seg_row;
			end
			booster_factor <= power_q[lcdp_pkg::PWR_BT_LSB +: 2];
			bias_select <= power_q[lcdp_pkg::PWR_BS_LSB +: 3];
			contrast_level <= contrast_q[5:0];
			osc_running <= clk_ok;
		end
	end

	// -------------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	chk_ptr_load: assert property (clk_en && acc.wr && !acc.rs |=> ptr_q == $past(acc.data))
		else $error("pointer not loaded by index write");
	chk_rd_ignored: assert property (clk_en && rd_edge && !register_select |=> db_out == 16'h0000)
		else $error("disabled read returned data");
	chk_dummy_read: assert property (clk_en && data_rd && !is_8b |=> db_out == $past(rstage_q))
		else $error("read did not return previous staging word");
	chk_addr_set: assert property (clk_en && addr_wr |=> ac_q == $past(acc.data[AW-1:0]))
		else $error("address set not loaded");
	chk_ac_wr_step: assert property (clk_en && ram_wr |=>
		ac_q == ($past(step_up) ? $past(ac_q) + 1'b1 : $past(ac_q) - 1'b1))
		else $error("counter did not step after write");
	chk_ac_rd_hold: assert property (clk_en && data_rd && !read_update_mode |=> $stable(ac_q))
		else $error("counter moved with read update off");
	chk_stage_drain: assert property ($rose(stage_pend_q) && push_ready |-> ##1 !stage_pend_q ||
		$past(ram_wr))
		else $error("staged write not pushed");
	chk_blank_out: assert property (clk_en && blank |=> com_out == '0 && seg_out == '0)
		else $error("outputs not blanked");
	chk_row_range: assert property (clk_en && rf_q == lcdp_pkg::RF_LATCH |=>
		row_q <= $past(last_row))
		else $error("row beyond programmed line count");
	chk_osc_halt: assert property (clk_en && stb |=> !osc_run_q ##1 !osc_running || !clk_en)
		else $error("oscillator running in standby");

	cov_ram_write: cover property (clk_en && ram_wr ##[1:40] drain_fire);
	cov_row_latch: cover property (rf_q == lcdp_pkg::RF_LATCH && !blank);
	cov_fifo_full: cover property (stage_pend_q && !push_ready);
	cov_serial_word: cover property (ser_done);

endmodule : lcdp_host_port
`default_nettype wire

// [verif/lcdp_host_model.sv]
// Host processor model driving the parallel and serial buses of the display port.
`timescale 1ns/1ps
`default_nettype none
module lcdp_host_model (
	// Clock
	input wire logic clk_sys,
	// Bus pins
	output logic cs_n,
	output logic register_select,
	output logic wr_n,
	output logic rd_n,
	output logic [15:0] db,
	// Read data from the device
	input wire logic [15:0] db_out
);
	initial begin
		cs_n = 1'b1;
		register_select = 1'b0;
		wr_n = 1'b1;
		rd_n = 1'b1;
		db = 16'h0000;
	end

	// A released bus shows the inverse of the last word, never a stale copy.
	task automatic wr(input logic sel, input logic [15:0] d, input logic cs);
		@(posedge clk_sys);
		cs_n <= cs;
		register_select <= sel;
		db <= d;
		wr_n <= 1'b0;
		@(posedge clk_sys);
		wr_n <= 1'b1;
		@(posedge clk_sys);
		cs_n <= 1'b1;
		db <= ~d;
		@(posedge clk_sys);
	endtask : wr

	task automatic reg_wr(input logic [15:0] idx, input logic [15:0] val);
		wr(1'b0, idx, 1'b0);
		wr(1'b1, val, 1'b0);
	endtask : reg_wr

	task automatic rd(output logic [15:0] q);
		rd_sel(1'b1, q);
	endtask : rd

	task automatic rd_sel(input logic sel, output logic [15:0] q);
		@(posedge clk_sys);
		cs_n <= 1'b0;
		register_select <= sel;
		rd_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1 q = db_out;
		@(posedge clk_sys);
		rd_n <= 1'b1;
		cs_n <= 1'b1;
	endtask : rd_sel

	// The enable strobe idles high here, so its falling edge alone carries the write.
	task automatic wr68(input logic sel, input logic [15:0] d);
		@(posedge clk_sys);
		cs_n <= 1'b0;
		register_select <= sel;
		db <= d;
		rd_n <= 1'b0;
		@(posedge clk_sys);
		wr_n <= 1'b0;
		@(posedge clk_sys);
		cs_n <= 1'b1;
		rd_n <= 1'b1;
		db <= ~d;
		wr_n <= 1'b1;
		@(posedge clk_sys);
	endtask : wr68

	// Serial frame: select bit, then sixteen data bits, most significant first.
	task automatic ser_wr(input logic sel, input logic [15:0] d);
		logic [16:0] f;
		f = {sel, d};
		@(posedge clk_sys);
		cs_n <= 1'b0;
		wr_n <= 1'b0;
		for (int i = 16; i >= 0; i--) begin
			rd_n <= f[i];
			@(posedge clk_sys);
			wr_n <= 1'b1;
			@(posedge clk_sys);
			wr_n <= 1'b0;
		end
		@(posedge clk_sys);
		cs_n <= 1'b1;
		wr_n <= 1'b1;
		rd_n <= 1'b1;
		@(posedge clk_sys);
	endtask : ser_wr
endmodule : lcdp_host_model
`default_nettype wire

// [verif/lcd_host_port_and_gram_access_bench.sv]
// Self-checking bench of the display host port.
`timescale 1ns/1ps
`default_nettype none
module lcd_host_port_and_gram_access_bench;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic cs_n, register_select, wr_n, rd_n, db_oe, osc_running;
	logic [15:0] db, db_out, q;
	logic [127:0] com_out, seg_out;
	logic [1:0] booster_factor;
	logic [2:0] bias_select;
	logic [5:0] contrast_level;
	logic [2:0] straps = lcdp_pkg::MODE_80_16;
	int miscompares = 0;
	int n_checks = 0;

	always #12.5 clk_sys = ~clk_sys;

	// The straps start on the 16-bit 80-style bus; the mode scenario visits 16-bit 68-style, serial and 8-bit 80-style.
	lcdp_host_port #(.OSC_SETTLE_CYCLES(8)) i_lcdp_host_port (.clk_sys(clk_sys), .rst_n(rst_n),
		.clk_en(1'b1), .interface_mode_straps(straps), .cs_n(cs_n),
		.register_select(register_select), .strobe_e_wr_scl(wr_n), .dir_rw_rd_sda(rd_n),
		.db_in(db), .db_out(db_out), .db_oe(db_oe), .com_out(com_out), .seg_out(seg_out),
		.booster_factor(booster_factor), .bias_select(bias_select),
		.contrast_level(contrast_level), .osc_running(osc_running));

	lcdp_host_model i_lcdp_host_model (.clk_sys(clk_sys), .cs_n(cs_n),
		.register_select(register_select), .wr_n(wr_n), .rd_n(rd_n), .db(db), .db_out(db_out));

	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic t_ram();
		i_lcdp_host_model.reg_wr(lcdp_pkg::IDX_ENTRY, 16'h0018);
		i_lcdp_host_model.reg_wr(lcdp_pkg::IDX_ADDR, 16'h07ff);
		i_lcdp_host_model.reg_wr(lcdp_pkg::IDX_RAM, 16'ha5c3);
		i_lcdp_host_model.wr(1'b1, 16'h3c5a, 1'b0);
		i_lcdp_host_model.reg_wr(lcdp_pkg::IDX_ADDR, 16'h07ff);
		i_lcdp_host_model.rd(q);
		i_lcdp_host_model.rd(q);
		chk(128'(q), 128'ha5c3);
		i_lcdp_host_model.rd(q);
		chk(128'(q), 128'h3c5a);
		i_lcdp_host_model.reg_wr(lcdp_pkg::IDX_ENTRY, 16'h0010);
		i_lcdp_host_model.reg_wr(lcdp_pkg::IDX_ADDR, 16'h07ff);
		repeat (3) i_lcdp_host_model.rd(q);
		chk(128'(q), 128'ha5c3);
		i_lcdp_host_model.rd_sel(1'b0, q);
		chk(128'(q), 128'h0);
	endtask : t_ram

	task automatic t_bitop();
		i_lcdp_host_model.reg_wr(lcdp_pkg::IDX_ROTATE, 16'h0004);
		i_lcdp_host_model.reg_wr(lcdp_pkg::IDX_ADDR, 16'h0010);
		i_lcdp_host_model.reg_wr(lcdp_pkg::IDX_RAM, 16'h1234);
		i_lcdp_host_model.reg_wr(lcdp_pkg::IDX_ADDR, 16'h0010);
		repeat (2) i_lcdp_host_model.rd(q);
		chk(128'(q), 128'h2341);
		i_lcdp_host_model.reg_wr(lcdp_pkg::IDX_MASK, 16'hff00);
		i_lcdp_host_model.reg_wr(lcdp_pkg::IDX_RAM, 16'hffff);
		i_lcdp_host_model.reg_wr(lcdp_pkg::IDX_ADDR, 16'h0010);
		repeat (2) i_lcdp_host_model.rd(q);
		chk(128'(q), 128'h23ff);
	endtask : t_bitop

	task automatic t_analog();
		i_lcdp_host_model.reg_wr(lcdp_pkg::IDX_POWER, 16'h3e00);
		i_lcdp_host_model.reg_wr(lcdp_pkg::IDX_CONTRAST, 16'h003f);
		@(negedge clk_sys);
		chk(128'({bias_select, booster_factor}), 128'h1f);
		chk(128'(contrast_level), 128'h3f);
		i_lcdp_host_model.wr(1'b1, 16'h0001, 1'b1);
		@(negedge clk_sys);
		chk(128'(contrast_level), 128'h3f);
	endtask : t_analog

	task automatic set_mode(input logic [2:0] m);
		@(posedge clk_sys);
		straps <= m;
		@(posedge clk_sys);
	endtask : set_mode

	// The pointer stays on the contrast register while each bus mode writes it.
	task automatic t_modes();
		set_mode(lcdp_pkg::MODE_68_16);
		i_lcdp_host_model.wr68(1'b0, lcdp_pkg::IDX_CONTRAST);
		i_lcdp_host_model.wr68(1'b1, 16'h002a);
		@(negedge clk_sys);
		chk(128'(contrast_level), 128'h2a);
		set_mode(lcdp_pkg::MODE_SERIAL);
		i_lcdp_host_model.ser_wr(1'b1, 16'h0015);
		@(negedge clk_sys);
		chk(128'(contrast_level), 128'h15);
		set_mode(lcdp_pkg::MODE_80_8);
		i_lcdp_host_model.wr(1'b1, 16'h0000, 1'b0);
		i_lcdp_host_model.wr(1'b1, 16'h3300, 1'b0);
		@(negedge clk_sys);
		chk(128'(contrast_level), 128'h33);
		set_mode(lcdp_pkg::MODE_80_16);
	endtask : t_modes

	task automatic t_blank();
		i_lcdp_host_model.reg_wr(lcdp_pkg::IDX_DISPLAY, 16'h0001);
		repeat (40) @(posedge clk_sys);
		chk(128'($countones(com_out)), 128'h1);
		i_lcdp_host_model.reg_wr(lcdp_pkg::IDX_POWER, 16'h3e01);
		repeat (4) @(posedge clk_sys);
		chk(com_out | seg_out, 128'h0);
		chk(128'(osc_running), 128'h0);
	endtask : t_blank

	task automatic final_report();
		$display("checks=%0d miscompares=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report

	initial begin
		#500000;
		miscompares++;
		final_report();
	end

	initial begin
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		chk(com_out | seg_out, 128'h0);
		t_ram();
		t_bitop();
		t_analog();
		t_modes();
		t_blank();
		final_report();
	end
endmodule : lcd_host_port_and_gram_access_bench
`default_nettype wire
